// >>> rtl/pdsl_regs.sv
// Device status and link capability/control/status register bank.
// Assumes same-clock event and training inputs, and an asynchronous
// AUX power pin that is synchronised here.

`timescale 1ns/1ns
`default_nettype none

module pdsl_regs #(
    parameter int          ADDR_W   = 8,
    parameter logic [5:0]  MAX_WID  = pdsl_pkg::WIDTH_X1,
    parameter logic [15:0] FTS_NORM = 16'h0080,
    parameter logic [15:0] TS1_NORM = 16'h0010
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    // Wishbone classic slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [ADDR_W-1:0]           wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // Events and status from the core
    input  wire pdsl_pkg::pdsl_err_type      err_evt,
    input  wire pdsl_pkg::pdsl_train_type    train,
    input  wire pdsl_pkg::pdsl_autoload_type autoload,
    input  wire logic                        aux_pwr_pin,
    // Controls toward the link layers
    output logic                             tx_l0s_en,
    output logic                             tx_l1_en,
    output logic                             rx_l0s_allow,
    output logic                             common_clk,
    output logic [15:0]                      fts_count,
    output logic [15:0]                      ts1_count,
    output pdsl_pkg::pdsl_err_type           err_msg
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 8 || ADDR_W > 12)
    begin : g_bad_addr
        $error("ADDR_W must lie between 8 and 12");
    end
    if (MAX_WID == 6'h00)
    begin : g_bad_wid
        $error("MAX_WID must not be zero");
    end

    // Byte-enable expansion, used by the detected-error write-one clear
    function automatic logic [31:0] be_mask(input logic [3:0] sel);
        be_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic       ack_q;
    logic [31:0] rdat_q;
    logic [3:0] rep_en_q;     // Reporting enables, device control 3:0
    logic [3:0] err_q;        // Detected-error bits
    logic       aux_m_q;      // Synchroniser first stage
    logic       aux_s_q;
    logic       aux_q;
    logic [1:0] aspm_sup_q;
    logic [2:0] l0s_lat_q;
    logic [2:0] l1_lat_q;
    logic [1:0] aspm_ctl_q;
    logic       cclk_q;
    logic       xsyn_q;
    logic       terr_q;
    logic       trn_q;
    logic [5:0] nwid_q;
    pdsl_pkg::pdsl_err_type msg_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire         req     = wb_cyc_i & wb_stb_i & ~ack_q;
    wire         wr      = req & wb_we_i;
    wire [7:0]   adr8    = {wb_adr_i[7:2], 2'b00};
    wire         hi_zero = ((wb_adr_i >> 8) == '0);  // Legal at ADDR_W=8
    wire         hit_dev = hi_zero & (adr8 == pdsl_pkg::OFF_DEV_CTL_STS);
    wire         hit_cap = hi_zero & (adr8 == pdsl_pkg::OFF_LINK_CAP);
    wire         hit_lnk = hi_zero & (adr8 == pdsl_pkg::OFF_LINK_CTL_STS);
    wire [31:0]  wmask   = be_mask(wb_sel_i);
    wire [31:0]  wbits   = wb_dat_i & wmask;
    wire         wr_dev  = wr & hit_dev;
    wire         wr_lnk  = wr & hit_lnk;

    // ------------------------------------------------------------------
    // Read words; every unlisted bit is a constant zero
    // ------------------------------------------------------------------
    wire [31:0] word_dev;
    wire [31:0] word_cap;
    wire [31:0] word_lnk;

    // Transactions pending and bits 31:22 stay zero
    assign word_dev = {10'h000, 1'b0, aux_q, err_q,
                       12'h000, rep_en_q};

    // Port number and reserved 23:18 stay zero
    assign word_cap = {8'h00, 6'h00, l1_lat_q, l0s_lat_q,
                       aspm_sup_q, MAX_WID,
                       pdsl_pkg::SPEED_2G5};

    // Slot clock, RCB, link disable, retrain and reserved read zero
    assign word_lnk = {3'h0, 1'b0, trn_q, terr_q, nwid_q,
                       pdsl_pkg::SPEED_2G5,
                       8'h00, xsyn_q, cclk_q, 3'h0,
                       1'b0, aspm_ctl_q};

    wire [31:0] rd_word = hit_dev ? word_dev :
                          hit_cap ? word_cap :
                          hit_lnk ? word_lnk : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Wishbone answer: ack one cycle after the request, data registered.
    // Unmapped addresses still get ack, read zero and ignore writes.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q  <= req;
            rdat_q <= (req & ~wb_we_i) ? rd_word : rdat_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------------
    // Device control enables and detected-error log
    // ------------------------------------------------------------------
    wire [3:0] err_in  = err_evt;
    wire [3:0] err_clr = wr_dev ? wbits[pdsl_pkg::DS_ERR_LSB +: 4] : 4'h0;

    // Set wins over a write-one clear in the same cycle; the log ignores
    // the enables so errors are seen even with messages turned off
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            err_q    <= 4'h0;
            rep_en_q <= 4'h0;
        end
        else
        begin
            err_q <= (err_q & ~err_clr) | err_in;
            if (wr_dev & wb_sel_i[0])
            begin
                rep_en_q <= wb_dat_i[3:0];
            end
        end
    end

    // Message requests go out only where reporting is enabled
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            msg_q <= '0;
        end
        else
        begin
            msg_q <= pdsl_pkg::pdsl_err_type'(err_in & rep_en_q);
        end
    end

    assign err_msg = msg_q;

    // ------------------------------------------------------------------
    // AUX power: pin passes three flops; shown bit resets high
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            aux_m_q <= 1'b1;
            aux_s_q <= 1'b1;
            aux_q   <= 1'b1;
        end
        else
        begin
            aux_m_q <= aux_pwr_pin;
            aux_s_q <= aux_m_q;
            aux_q   <= aux_s_q;
        end
    end

    // ------------------------------------------------------------------
    // Capability fields: reset defaults, replaced only by the loader.
    // Bus writes never reach them.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            aspm_sup_q <= pdsl_pkg::ASPM_SUP_RST;
            l0s_lat_q  <= pdsl_pkg::L0S_LAT_RST;
            l1_lat_q   <= pdsl_pkg::L1_LAT_RST;
        end
        else if (autoload.load)
        begin
            aspm_sup_q <= autoload.aspm_sup;
            l0s_lat_q  <= autoload.l0s_lat;
            l1_lat_q   <= autoload.l1_lat;
        end
    end

    // ------------------------------------------------------------------
    // Link control: only bits 1:0, 6 and 7 take writes
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            aspm_ctl_q <= pdsl_pkg::ASPM_CTL_RST;
            cclk_q     <= 1'b0;
            xsyn_q     <= 1'b0;
        end
        else if (wr_lnk & wb_sel_i[0])
        begin
            aspm_ctl_q <= wb_dat_i[pdsl_pkg::LK_ASPM_LSB +: 2];
            cclk_q     <= wb_dat_i[pdsl_pkg::LK_CCLK_BIT];
            xsyn_q     <= wb_dat_i[pdsl_pkg::LK_XSYN_BIT];
        end
    end

    // ASPM decode limits the transmitter only
    wire [1:0] aspm_ctl = aspm_ctl_q;
    assign tx_l0s_en    = (aspm_ctl == pdsl_pkg::PDSL_ASPM_L0S) |
                          (aspm_ctl == pdsl_pkg::PDSL_ASPM_BOTH);
    assign tx_l1_en     = (aspm_ctl == pdsl_pkg::PDSL_ASPM_L1) |
                          (aspm_ctl == pdsl_pkg::PDSL_ASPM_BOTH);
    assign rx_l0s_allow = 1'b1;
    assign common_clk   = cclk_q;
    // Long sync sets cost exit time; only used when software asks
    assign fts_count    = xsyn_q ? pdsl_pkg::FTS_EXT : FTS_NORM;
    assign ts1_count    = xsyn_q ? pdsl_pkg::TS1_EXT : TS1_NORM;

    // ------------------------------------------------------------------
    // Link training status; failure wins over success in one cycle
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            terr_q <= 1'b0;
            trn_q  <= 1'b0;
            nwid_q <= 6'h00;
        end
        else
        begin
            if (train.fail)
            begin
                terr_q <= 1'b1;
            end
            else if (train.l0_ok)
            begin
                terr_q <= 1'b0;
            end
            trn_q <= train.active;
            if (train.l0_ok)
            begin
                nwid_q <= train.width;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_wr_link;
        wr_lnk & wb_sel_i[0];
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    AST_ERR_LOGGED: assert property (
        err_evt.corr |=> err_q[0] && word_dev[pdsl_pkg::DS_ERR_LSB])
        else $error("Correctable error not logged");

    AST_ERR_NO_ENABLE: assert property (
        (err_evt.fatal && !rep_en_q[2]) |=> err_q[2] && !err_msg.fatal)
        else $error("Fatal error lost while reporting disabled");

    AST_ERR_HOLD: assert property (
        (err_q[3] && !(wr_dev && wb_sel_i[2] && wb_dat_i[19]))
        |=> err_q[3])
        else $error("UR bit dropped without a write of one");

    AST_ACK_ONE: assert property (
        req |=> s_ack_pulse)
        else $error("Ack is not a single cycle after the request");

    AST_RO_ZERO: assert property (
        word_dev[31:21] == 11'h000 && word_cap[31:18] == 14'h0000 &&
        word_lnk[31:28] == 4'h0 && word_lnk[5:2] == 4'h0)
        else $error("Reserved or unimplemented bits read nonzero");

    AST_CAP_STEADY: assert property (
        (wr && hit_cap && !autoload.load) |=> $stable(word_cap))
        else $error("Capability word changed by a bus write");

    AST_ASPM_DECODE: assert property (
        s_wr_link |=> tx_l1_en == $past(wb_dat_i[1]) &&
                      tx_l0s_en == $past(wb_dat_i[0]))
        else $error("ASPM enables do not follow control field");

    AST_EXT_SYNC: assert property (
        xsyn_q |-> fts_count == 16'h1000 && ts1_count == 16'h0400)
        else $error("Extended synch counts wrong");

    AST_TERR: assert property (
        (train.l0_ok && !train.fail) |=> !word_lnk[pdsl_pkg::LS_TERR_BIT])
        else $error("Training error not cleared on reaching L0");

    AST_TERR_SET: assert property (
        train.fail |=> word_lnk[pdsl_pkg::LS_TERR_BIT])
        else $error("Training error not set on a failed training");

    AST_TRAINING: assert property (
        $rose(train.active) |=> word_lnk[pdsl_pkg::LS_TRN_BIT])
        else $error("Link training bit does not follow training");

    AST_MSG_GATE: assert property (
        (err_evt.corr && rep_en_q[0]) |=> err_msg.corr ##1
        (!err_msg.corr || $past(err_evt.corr && rep_en_q[0])))
        else $error("Correctable message not sent when enabled");

endmodule

`default_nettype wire

// >>> rtl/pdsl_pkg.sv
// Package for the device status and link capability/control/status bank.
// Assumes a 32-bit classic Wishbone slave on a single core clock.
`default_nettype none
package pdsl_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_DEV_CTL_STS  = 8'he8;
    localparam logic [7:0] OFF_LINK_CAP     = 8'hec;
    localparam logic [7:0] OFF_LINK_CTL_STS = 8'hf0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DS_ERR_LSB   = 16;   // Four detected-error bits 19:16
    localparam int DS_AUX_BIT   = 20;
    localparam int LC_SPD_LSB   = 0;
    localparam int LC_WID_LSB   = 4;
    localparam int LC_ASPM_LSB  = 10;
    localparam int LC_L0S_LSB   = 12;
    localparam int LC_L1_LSB    = 15;
    localparam int LK_ASPM_LSB  = 0;
    localparam int LK_CCLK_BIT  = 6;
    localparam int LK_XSYN_BIT  = 7;
    localparam int LS_SPD_LSB   = 16;
    localparam int LS_WID_LSB   = 20;
    localparam int LS_TERR_BIT  = 26;
    localparam int LS_TRN_BIT   = 27;

    // ------------------------------------------------------------------
    // Reset and fixed values
    // ------------------------------------------------------------------
    localparam logic [3:0] SPEED_2G5       = 4'h1;
    localparam logic [5:0] WIDTH_X1        = 6'h01;
    localparam logic [1:0] ASPM_SUP_RST    = 2'h3;
    localparam logic [2:0] L0S_LAT_RST     = 3'h3;
    localparam logic [2:0] L1_LAT_RST      = 3'h0;
    localparam logic [1:0] ASPM_CTL_RST    = 2'h0;
    localparam logic [15:0] FTS_EXT        = 16'h1000;  // 4096 sets
    localparam logic [15:0] TS1_EXT        = 16'h0400;  // 1024 sets

    // ASPM control encodings
    typedef enum logic [1:0] {
        PDSL_ASPM_OFF  = 2'h0,
        PDSL_ASPM_L0S  = 2'h1,
        PDSL_ASPM_L1   = 2'h2,
        PDSL_ASPM_BOTH = 2'h3
    } pdsl_aspm_type;

    // Error events, one-cycle pulses, one bit per class
    typedef struct packed {
        logic ur;
        logic fatal;
        logic nonfatal;
        logic corr;
    } pdsl_err_type;

    // Link training progress from the LTSSM
    typedef struct packed {
        logic       active;
        logic       fail;
        logic       l0_ok;
        logic [5:0] width;
    } pdsl_train_type;

    // Capability values delivered by the EEPROM loader
    typedef struct packed {
        logic       load;
        logic [1:0] aspm_sup;
        logic [2:0] l0s_lat;
        logic [2:0] l1_lat;
    } pdsl_autoload_type;

endpackage
`default_nettype wire

// >>> test/pdsl_host_model.sv
// Configuration-software model: classic Wishbone master, single cycles.
// Assumes one core clock; the bench watchdog bounds every wait.
`timescale 1ns/1ns
`default_nettype none
module pdsl_host_model (
    // Clock
    input  wire logic        core_clk,
    // Wishbone master side
    output logic             wb_cyc,
    output logic             wb_stb,
    output logic             wb_we,
    output logic [7:0]       wb_adr,
    output logic [3:0]       wb_sel,
    output logic [31:0]      wb_dat_w,
    input  wire logic [31:0] wb_dat_r,
    input  wire logic        wb_ack
);
    // Idle bus from time zero
    initial
    begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
    end

    // Request stands until ack is sampled high; released data lines get
    // the inverse so a stale value can never pass for a fresh one
    task automatic xfer(
        input  logic        we,
        input  logic [7:0]  adr,
        input  logic [3:0]  sel,
        input  logic [31:0] dat,
        output logic [31:0] rd
    );
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= dat;
        do
            @(posedge core_clk);
        while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_adr <= ~adr;
        wb_dat_w <= ~dat;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_pdsl_regs.sv
// Self-checking bench for the device status and link register bank.
// Assumes the host model speaks Wishbone; the bench drives core events.
`timescale 1ns/1ns
`default_nettype none
module tb_pdsl_regs;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                        core_clk;
    logic                        sys_rst;
    logic                        wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]                  wb_adr;
    logic [3:0]                  wb_sel;
    logic [31:0]                 wb_dat_w, wb_dat_r;
    pdsl_pkg::pdsl_err_type      err_evt, err_msg;
    pdsl_pkg::pdsl_train_type    train;
    pdsl_pkg::pdsl_autoload_type autoload;
    logic                        aux_pwr_pin, common_clk, rx_l0s_allow;
    logic                        tx_l0s_en, tx_l1_en;
    logic [15:0]                 fts_count, ts1_count;
    int                          err_count = 0;
    int                          checks = 0;

    // Clock, 8 ns period
    always #4 core_clk = ~core_clk;

    pdsl_host_model u_host (.core_clk(core_clk), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

    pdsl_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .err_evt(err_evt),
        .train(train), .autoload(autoload), .aux_pwr_pin(aux_pwr_pin),
        .tx_l0s_en(tx_l0s_en), .tx_l1_en(tx_l1_en),
        .rx_l0s_allow(rx_l0s_allow), .common_clk(common_clk),
        .fts_count(fts_count), .ts1_count(ts1_count), .err_msg(err_msg));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        u_host.xfer(1'b0, adr, 4'hf, 32'h0, rd);
        chk($sformatf("reg_%h", adr), rd, exp);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        logic [31:0] rd;
        u_host.xfer(1'b1, adr, sel, dat, rd);
    endtask

    // Link-side controls; settle past the edge before looking
    task automatic out_chk(input logic [1:0] aspm, input logic cc, xs);
        #1;
        chk("ctl", {28'h0, rx_l0s_allow, common_clk, tx_l1_en, tx_l0s_en},
            {28'h0, 1'b1, cc, aspm});
        chk("sets", {fts_count, ts1_count},
            xs ? 32'h1000_0400 : 32'h0080_0010);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(8'he8, 32'h0010_0000);
        rd_chk(8'hec, 32'h0000_3c11);
        rd_chk(8'hf0, 32'h0001_0000);
        out_chk(2'h0, 1'b0, 1'b0);
        chk("msg", {28'h0, err_msg}, 32'h0);
    endtask

    // Writes of ones to read-only, reserved and unmapped places
    task automatic t_ro();
        wr(8'he8, 4'hf, 32'hffef_fff0);
        rd_chk(8'he8, 32'h0010_0000);
        wr(8'hec, 4'hf, 32'hffff_ffff);
        rd_chk(8'hec, 32'h0000_3c11);
        wr(8'hf0, 4'hf, 32'hffff_ff3c);
        rd_chk(8'hf0, 32'h0001_0000);
        wr(8'hf4, 4'hf, 32'hffff_ffff);
        rd_chk(8'hf4, 32'h0);
    endtask

    // Every ASPM code with both clock and synch settings
    task automatic t_aspm();
        logic [3:0] v;
        for (int i = 0; i < 16; i++)
        begin
            v = i[3:0];
            wr(8'hf0, 4'h1, {24'hffffff, v[3], v[2], 4'hf, v[1:0]});
            out_chk(v[1:0], v[2], v[3]);
            rd_chk(8'hf0, {16'h0001, 8'h0, v[3:2], 4'h0, v[1:0]});
        end
        wr(8'hf0, 4'h1, 32'h0);
    endtask

    // Each class logged with reporting off, then on
    task automatic t_errors();
        logic [31:0] b;
        logic [31:0] c;
        for (int k = 0; k < 8; k++)
        begin
            b = 32'h1 << (16 + k[1:0]);
            c = {28'h0, {4{k[2]}}};
            wr(8'he8, 4'hf, c);
            @(posedge core_clk);
            err_evt <= pdsl_pkg::pdsl_err_type'(4'h1 << k[1:0]);
            @(posedge core_clk);
            err_evt <= '0;
            #1;
            chk("msg", {28'h0, err_msg}, k[2] ? b >> 16 : 32'h0);
            @(posedge core_clk);
            #1;
            chk("msg_end", {28'h0, err_msg}, 32'h0);
            rd_chk(8'he8, 32'h0010_0000 | b | c);
            wr(8'he8, 4'hf, c);
            rd_chk(8'he8, 32'h0010_0000 | b | c);
            wr(8'he8, 4'hf, b | c);
            rd_chk(8'he8, 32'h0010_0000 | c);
        end
        wr(8'he8, 4'hf, 32'h0);
    endtask

    // Training runs, fails, then reaches L0 with one lane
    task automatic t_train();
        @(posedge core_clk);
        train.active <= 1'b1;
        train.width <= 6'h01;
        repeat (2) @(posedge core_clk);
        rd_chk(8'hf0, 32'h0801_0000);
        train.fail <= 1'b1;
        @(posedge core_clk);
        train.fail <= 1'b0;
        rd_chk(8'hf0, 32'h0c01_0000);
        train.active <= 1'b0;
        train.l0_ok <= 1'b1;
        @(posedge core_clk);
        train.l0_ok <= 1'b0;
        rd_chk(8'hf0, 32'h0011_0000);
    endtask

    // Loader replaces capability fields; AUX follows its pin
    task automatic t_load_aux();
        @(posedge core_clk);
        autoload <= {1'b1, 2'h1, 3'h5, 3'h2};
        @(posedge core_clk);
        autoload.load <= 1'b0;
        rd_chk(8'hec, 32'h0001_5411);
        aux_pwr_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd_chk(8'he8, 32'h0);
        aux_pwr_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd_chk(8'he8, 32'h0010_0000);
    endtask

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run needs well under 2000 cycles
    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        finish_test();
    end

    initial
    begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        err_evt = '0;
        train = '0;
        autoload = '0;
        aux_pwr_pin = 1'b1;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_ro();
        t_aspm();
        t_errors();
        t_train();
        t_load_aux();
        finish_test();
    end
endmodule
`default_nettype wire
